// ### pkg/conv_ctrl_map.vh
`ifndef CONV_CTRL_MAP_VH
`define CONV_CTRL_MAP_VH
// ==========================================================
// Register offsets
`define OFS_CLOCK_REFERENCE_CONFIG 5'h02
`define OFS_DELAY_CONFIG 5'h03
`define OFS_WINDOW_MODE_CONFIG 5'h04
`define OFS_SAMPLE_LENGTH_CONFIG 5'h05
`define OFS_INPUT_CHANNEL_SELECT 5'h06
`define OFS_CONVERSION_COMMAND 5'h08
`define OFS_CONTROL 5'h09
`define OFS_INT_MASK 5'h0A
`define OFS_INT_FLAGS 5'h0B
`define OFS_RESULT_LO 5'h10
`define OFS_RESULT_HI 5'h11
`define OFS_LOW_THR_LO 5'h12
`define OFS_LOW_THR_HI 5'h13
`define OFS_HIGH_THR_LO 5'h14
`define OFS_HIGH_THR_HI 5'h15
// ==========================================================
// Field positions
`define POS_CLOCK_DIVIDER 0
`define POS_REFERENCE_SELECT 4
`define POS_SAMPLE_CAP_SELECT 6
`define POS_SAMPLE_SPACING 0
`define POS_DELAY_VARIATION 4
`define POS_STARTUP_DELAY 5
`define POS_ENABLE 0
`define POS_SLEEP_WAKE 1
`define POS_RESULT_READY 0
`define POS_WINDOW_MATCH 1
// ==========================================================
// Reset values and codes
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define WIN_NONE 3'h0
`define WIN_BELOW 3'h1
`define WIN_ABOVE 3'h2
`define WIN_INSIDE 3'h3
`define WIN_OUTSIDE 3'h4
`define REF_INTERNAL 2'h0
`define SAMPLE_BASE_CYCLES 6'h02
`define CONVERT_CYCLES 5'h0A
`endif

// ### rtl/conv_clock_enable.v
`timescale 1ns/1ps
// ==========================================================
// Converter clock enable: one pulse every 2^(code+1) cycles
module conv_clock_enable
(
	// Clock and reset
	input wire ref_clk,
	input wire rstn,
	// Divider code
	input wire [2:0] clock_divider,
	// Converter tick
	output wire conv_tick
);
reg [7:0] div_cnt_ff;
reg [7:0] limit;
always @*
begin
	// Right shift keeps every step inside eight bits, code 7 gives 255
	limit = 8'hFF >> (3'h7 - clock_divider);
end
always @(posedge ref_clk)
begin
	if (!rstn)
		div_cnt_ff <= 8'h00;
	else if (div_cnt_ff >= limit)
		div_cnt_ff <= 8'h00;
	else
		div_cnt_ff <= div_cnt_ff + 8'h01;
end
assign conv_tick = (div_cnt_ff >= limit);
endmodule // conv_clock_enable

// ### rtl/window_compare.v
`timescale 1ns/1ps
`include "conv_ctrl_map.vh"
// ==========================================================
// Window comparator on the accumulated result
module window_compare
(
	// Operands
	input wire [2:0] window_mode,
	input wire [15:0] result_value,
	input wire [15:0] low_threshold,
	input wire [15:0] high_threshold,
	// Match
	output reg match
);
wire below = result_value < low_threshold;
wire above = result_value > high_threshold;
always @*
begin
	case (window_mode)
	`WIN_BELOW: match = below;
	`WIN_ABOVE: match = above;
	`WIN_INSIDE: match = (result_value > low_threshold) && (result_value < high_threshold);
	`WIN_OUTSIDE: match = below || above;
	default: match = 1'b0;
	endcase
end
endmodule // window_compare

// ### rtl/conv_timing_ctrl.v
`timescale 1ns/1ps
`include "conv_ctrl_map.vh"
// Function
// - Divider code 0..7 selects peripheral clock division by 2 up to 256.
// - Reference select: 0 internal, 1 supply, other codes reserved.
// - Sample cap bit set drives reduced sampling capacitance.
// - Startup delay 0,16,32,64,128,256 converter cycles before first sample.
// - Startup delay also applies when waking from deep sleep to measure.
// - Delay variation adds one to sample spacing after every sample.
// - Sample spacing wraps from 0xF to 0x0 under variation.
// - Wait sample spacing converter cycles between samples, unscaled.
// - Sampling switch held open during the inter-sample delay.
// - Window mode selects none, below, above, inside or outside.
// - Comparison uses full 16-bit result and thresholds.
// - Sampling lasts two cycles plus sample length field.
// - Input select routes pins, converter output, reference, sensor, ground.
// - Input select change takes effect only after the running conversion.
// - Start bit begins, reads one while busy, self-clears, zero write aborts.
// - Result ready sets on completion, clears by write one or result read.
// - Window match evaluated at conversion end, cleared like result ready.
module conv_timing_ctrl
#(
	parameter SAMPLES_PER_RESULT = 1
)
(
	// Clock and reset
	input wire ref_clk,
	input wire rstn,
	// Register port
	input wire [4:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Analog core
	input wire [9:0] sample_data,
	output reg sample_switch_closed,
	output reg [4:0] active_channel,
	output reg [1:0] reference_select,
	output reg sample_cap_select,
	output reg converting,
	// Interrupt
	output wire irq
);
// ==========================================================
// Registers
reg [7:0] clock_reference_config_ff;
reg [7:0] delay_config_ff;
reg [7:0] window_mode_config_ff;
reg [7:0] sample_length_config_ff;
reg [7:0] input_channel_select_ff;
reg [7:0] control_ff;
reg [7:0] int_mask_ff;
reg [1:0] int_flags_ff;
reg [15:0] result_ff;
reg [15:0] low_threshold_ff;
reg [15:0] high_threshold_ff;
reg start_ff;
reg [7:0] rdata_nxt;
wire conv_tick;
wire win_match;
wire wr_hit_start = reg_wr && (reg_addr == `OFS_CONVERSION_COMMAND);
wire rd_result = reg_rd && ((reg_addr == `OFS_RESULT_LO) || (reg_addr == `OFS_RESULT_HI));
// ==========================================================
// Sequencer states
localparam ST_IDLE = 3'h0;
localparam ST_INIT = 3'h1;
localparam ST_SAMPLE = 3'h2;
localparam ST_CONVERT = 3'h3;
localparam ST_SPACE = 3'h4;
localparam ST_DONE = 3'h5;
reg [2:0] state_ff;
reg [8:0] cnt_ff;
reg [15:0] acc_ff;
reg [6:0] samples_ff;
reg done_pulse;
reg enable_prev_ff;
reg ref_prev_ff;
reg init_pending_ff;
wire [2:0] startup_code = delay_config_ff[`POS_STARTUP_DELAY +: 3];
wire [3:0] spacing = delay_config_ff[`POS_SAMPLE_SPACING +: 4];
function [8:0] startup_cycles;
	input [2:0] code;
	begin
		if (code == 3'h0 || code > 3'h5)
			startup_cycles = 9'h000;
		else
			startup_cycles = 9'h008 << code;
	end
endfunction
function [8:0] sample_load;
	input [4:0] len;
	begin
		sample_load = {3'h0, `SAMPLE_BASE_CYCLES} + {4'h0, len} - 9'h001;
	end
endfunction
// ==========================================================
// Submodules
conv_clock_enable u_clk
(
	.ref_clk(ref_clk),
	.rstn(rstn),
	.clock_divider(clock_reference_config_ff[`POS_CLOCK_DIVIDER +: 3]),
	.conv_tick(conv_tick)
);
window_compare u_win
(
	.window_mode(window_mode_config_ff[2:0]),
	.result_value(acc_ff),
	.low_threshold(low_threshold_ff),
	.high_threshold(high_threshold_ff),
	.match(win_match)
);
// ==========================================================
// Register writes
always @(posedge ref_clk)
begin
	if (!rstn)
	begin
		clock_reference_config_ff <= `RST_BYTE;
		window_mode_config_ff <= `RST_BYTE;
		sample_length_config_ff <= `RST_BYTE;
		input_channel_select_ff <= `RST_BYTE;
		control_ff <= `RST_BYTE;
		int_mask_ff <= `RST_BYTE;
		low_threshold_ff <= `RST_WORD;
		high_threshold_ff <= `RST_WORD;
	end
	else if (reg_wr)
	begin
		case (reg_addr)
		`OFS_CLOCK_REFERENCE_CONFIG: clock_reference_config_ff <= reg_wdata & 8'h77;
		`OFS_WINDOW_MODE_CONFIG: window_mode_config_ff <= reg_wdata & 8'h07;
		`OFS_SAMPLE_LENGTH_CONFIG: sample_length_config_ff <= reg_wdata & 8'h1F;
		`OFS_INPUT_CHANNEL_SELECT: input_channel_select_ff <= reg_wdata & 8'h1F;
		`OFS_CONTROL: control_ff <= reg_wdata & 8'h03;
		`OFS_INT_MASK: int_mask_ff <= reg_wdata & 8'h03;
		`OFS_LOW_THR_LO: low_threshold_ff[7:0] <= reg_wdata;
		`OFS_LOW_THR_HI: low_threshold_ff[15:8] <= reg_wdata;
		`OFS_HIGH_THR_LO: high_threshold_ff[7:0] <= reg_wdata;
		`OFS_HIGH_THR_HI: high_threshold_ff[15:8] <= reg_wdata;
		default: ;
		endcase
	end
end
// ==========================================================
// Delay config: software write, hardware increments spacing
always @(posedge ref_clk)
begin
	if (!rstn)
		delay_config_ff <= `RST_BYTE;
	else if (reg_wr && reg_addr == `OFS_DELAY_CONFIG)
		delay_config_ff <= reg_wdata;
	else if (state_ff == ST_SAMPLE && conv_tick && cnt_ff == 9'h000 && delay_config_ff[`POS_DELAY_VARIATION])
		delay_config_ff[3:0] <= spacing + 4'h1;
end
// ==========================================================
// Startup-delay triggers
always @(posedge ref_clk)
begin
	if (!rstn)
	begin
		enable_prev_ff <= 1'b0;
		// Reset reference is internal, so no false edge after reset
		ref_prev_ff <= 1'b1;
		init_pending_ff <= 1'b0;
	end
	else
	begin
		enable_prev_ff <= control_ff[`POS_ENABLE];
		ref_prev_ff <= (clock_reference_config_ff[5:4] == `REF_INTERNAL);
		if ((control_ff[`POS_ENABLE] && !enable_prev_ff) ||
			((clock_reference_config_ff[5:4] == `REF_INTERNAL) && !ref_prev_ff) ||
			control_ff[`POS_SLEEP_WAKE])
			init_pending_ff <= 1'b1;
		else if (state_ff == ST_INIT)
			init_pending_ff <= 1'b0;
	end
end
// ==========================================================
// Conversion sequencer
always @(posedge ref_clk)
begin
	done_pulse <= 1'b0;
	if (!rstn)
	begin
		state_ff <= ST_IDLE;
		cnt_ff <= 9'h000;
		acc_ff <= `RST_WORD;
		samples_ff <= 7'h00;
		start_ff <= 1'b0;
		active_channel <= 5'h00;
		result_ff <= `RST_WORD;
		done_pulse <= 1'b0;
	end
	else if (wr_hit_start && !reg_wdata[0] && start_ff)
	begin
		start_ff <= 1'b0;
		state_ff <= ST_IDLE;
	end
	else
	begin
		case (state_ff)
		ST_IDLE:
		begin
			active_channel <= input_channel_select_ff[4:0];
			if (wr_hit_start && reg_wdata[0])
			begin
				start_ff <= 1'b1;
				acc_ff <= `RST_WORD;
				samples_ff <= 7'h00;
				cnt_ff <= init_pending_ff ? startup_cycles(startup_code) : 9'h000;
				state_ff <= ST_INIT;
			end
		end
		// Waiting phases end on a tick, so sampling spans whole converter cycles
		ST_INIT:
			if (conv_tick)
			begin
				if (cnt_ff == 9'h000)
				begin
					cnt_ff <= sample_load(sample_length_config_ff[4:0]);
					state_ff <= ST_SAMPLE;
				end
				else
					cnt_ff <= cnt_ff - 9'h001;
			end
		ST_SAMPLE:
			if (conv_tick)
			begin
				if (cnt_ff == 9'h000)
				begin
					cnt_ff <= {4'h0, `CONVERT_CYCLES} - 9'h001;
					state_ff <= ST_CONVERT;
				end
				else
					cnt_ff <= cnt_ff - 9'h001;
			end
		ST_CONVERT:
			if (conv_tick)
			begin
				if (cnt_ff == 9'h000)
				begin
					acc_ff <= acc_ff + {6'h00, sample_data};
					samples_ff <= samples_ff + 7'h01;
					if (samples_ff + 7'h01 >= SAMPLES_PER_RESULT)
						state_ff <= ST_DONE;
					else if (spacing == 4'h0)
					begin
						cnt_ff <= sample_load(sample_length_config_ff[4:0]);
						state_ff <= ST_SAMPLE;
					end
					else
					begin
						cnt_ff <= {5'h00, spacing} - 9'h001;
						state_ff <= ST_SPACE;
					end
				end
				else
					cnt_ff <= cnt_ff - 9'h001;
			end
		ST_SPACE:
			if (conv_tick)
			begin
				if (cnt_ff == 9'h000)
				begin
					cnt_ff <= sample_load(sample_length_config_ff[4:0]);
					state_ff <= ST_SAMPLE;
				end
				else
					cnt_ff <= cnt_ff - 9'h001;
			end
		ST_DONE:
		begin
			result_ff <= acc_ff;
			done_pulse <= 1'b1;
			start_ff <= 1'b0;
			state_ff <= ST_IDLE;
		end
		default: state_ff <= ST_IDLE;
		endcase
	end
end
// ==========================================================
// Interrupt flags: set wins over clear
always @(posedge ref_clk)
begin
	if (!rstn)
		int_flags_ff <= 2'h0;
	else
	begin
		if (done_pulse)
			int_flags_ff[`POS_RESULT_READY] <= 1'b1;
		else if (rd_result || (reg_wr && reg_addr == `OFS_INT_FLAGS && reg_wdata[`POS_RESULT_READY]))
			int_flags_ff[`POS_RESULT_READY] <= 1'b0;
		if (done_pulse && win_match)
			int_flags_ff[`POS_WINDOW_MATCH] <= 1'b1;
		else if (rd_result || (reg_wr && reg_addr == `OFS_INT_FLAGS && reg_wdata[`POS_WINDOW_MATCH]))
			int_flags_ff[`POS_WINDOW_MATCH] <= 1'b0;
	end
end
assign irq = |(int_flags_ff & int_mask_ff[1:0]);
// ==========================================================
// Analog-side outputs
always @(posedge ref_clk)
begin
	if (!rstn)
	begin
		sample_switch_closed <= 1'b0;
		reference_select <= 2'h0;
		sample_cap_select <= 1'b0;
		converting <= 1'b0;
	end
	else
	begin
		sample_switch_closed <= (state_ff == ST_SAMPLE);
		reference_select <= clock_reference_config_ff[`POS_REFERENCE_SELECT +: 2];
		sample_cap_select <= clock_reference_config_ff[`POS_SAMPLE_CAP_SELECT];
		converting <= start_ff;
	end
end
// ==========================================================
// Read data, one cycle after the strobe
always @*
begin
	case (reg_addr)
	`OFS_CLOCK_REFERENCE_CONFIG: rdata_nxt = clock_reference_config_ff;
	`OFS_DELAY_CONFIG: rdata_nxt = delay_config_ff;
	`OFS_WINDOW_MODE_CONFIG: rdata_nxt = window_mode_config_ff;
	`OFS_SAMPLE_LENGTH_CONFIG: rdata_nxt = sample_length_config_ff;
	`OFS_INPUT_CHANNEL_SELECT: rdata_nxt = input_channel_select_ff;
	`OFS_CONVERSION_COMMAND: rdata_nxt = {7'h00, start_ff};
	`OFS_CONTROL: rdata_nxt = control_ff;
	`OFS_INT_MASK: rdata_nxt = int_mask_ff;
	`OFS_INT_FLAGS: rdata_nxt = {6'h00, int_flags_ff};
	`OFS_RESULT_LO: rdata_nxt = result_ff[7:0];
	`OFS_RESULT_HI: rdata_nxt = result_ff[15:8];
	`OFS_LOW_THR_LO: rdata_nxt = low_threshold_ff[7:0];
	`OFS_LOW_THR_HI: rdata_nxt = low_threshold_ff[15:8];
	`OFS_HIGH_THR_LO: rdata_nxt = high_threshold_ff[7:0];
	`OFS_HIGH_THR_HI: rdata_nxt = high_threshold_ff[15:8];
	default: rdata_nxt = 8'h00;
	endcase
end
always @(posedge ref_clk)
begin
	if (!rstn)
		reg_rdata <= 8'h00;
	else if (reg_rd)
		reg_rdata <= rdata_nxt;
	else
		reg_rdata <= 8'h00;
end
endmodule // conv_timing_ctrl

// ### verif/conv_timing_ctrl_assertions.sv
`timescale 1ns/1ps
`include "conv_ctrl_map.vh"
module conv_timing_ctrl_assertions
#(
	parameter SAMPLES_PER_RESULT = 1
)
(
	// Clock and reset
	input wire ref_clk,
	input wire rstn,
	// Register port
	input wire [4:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// Analog core
	input wire [9:0] sample_data,
	input wire sample_switch_closed,
	input wire [4:0] active_channel,
	input wire [1:0] reference_select,
	input wire sample_cap_select,
	input wire converting,
	// Interrupt
	input wire irq
);
	// ==========================================================
	// Sequences
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence s_start_wr;
		reg_wr && reg_addr == `OFS_CONVERSION_COMMAND && reg_wdata[0] && !converting;
	endsequence
	sequence s_stop_wr;
		reg_wr && reg_addr == `OFS_CONVERSION_COMMAND && !reg_wdata[0] && converting;
	endsequence
	sequence s_cfg_wr;
		reg_wr && reg_addr == `OFS_CLOCK_REFERENCE_CONFIG ##2 1'b1;
	endsequence
	// ==========================================================
	// Checks
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside read");
	a_busy_bit: assert property ($past(reg_rd && reg_addr == `OFS_CONVERSION_COMMAND) |->
		reg_rdata == {7'h00, converting})
		else $error("start bit read differs from busy");
	a_flag_unused: assert property ($past(reg_rd && reg_addr == `OFS_INT_FLAGS) |->
		reg_rdata[7:2] == 6'h00)
		else $error("unused flag bits not zero");
	a_start_busy: assert property (s_start_wr |-> ##[1:2] converting)
		else $error("start did not begin conversion");
	a_stop_idle: assert property (s_stop_wr |-> ##[1:2] !converting)
		else $error("zero write did not abort");
	a_chan_frozen: assert property (converting && $past(converting) |-> $stable(active_channel))
		else $error("channel changed during conversion");
	a_switch_idle: assert property (!converting && !$past(converting) |-> !sample_switch_closed)
		else $error("switch closed while idle");
	a_cfg_copy: assert property (s_cfg_wr |-> reference_select == $past(reg_wdata[5:4], 2)
		&& sample_cap_select == $past(reg_wdata[6], 2))
		else $error("reference or cap output wrong");
endmodule // conv_timing_ctrl_assertions
bind conv_timing_ctrl conv_timing_ctrl_assertions #(.SAMPLES_PER_RESULT(SAMPLES_PER_RESULT)) u_chk
	(.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_data(sample_data),
	.sample_switch_closed(sample_switch_closed), .active_channel(active_channel),
	.reference_select(reference_select), .sample_cap_select(sample_cap_select),
	.converting(converting), .irq(irq));

// ### verif/adc_timing_window_mux_control_tb_top.sv
`timescale 1ns/1ps
module adc_timing_window_mux_control_tb_top;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [9:0] sample_data = 10'h155;
	logic [7:0] rv;
	wire [7:0] reg_rdata;
	wire sample_switch_closed;
	wire sample_cap_select;
	wire converting;
	wire irq;
	wire [4:0] active_channel;
	wire [1:0] reference_select;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int cl;
	int st;
	int tot;
	int t0;
	conv_timing_ctrl #(.SAMPLES_PER_RESULT(2)) uut (.ref_clk(ref_clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sample_data(sample_data), .sample_switch_closed(sample_switch_closed),
		.active_channel(active_channel), .reference_select(reference_select),
		.sample_cap_select(sample_cap_select), .converting(converting), .irq(irq));
	// ==========================================================
	// Clock and watchdog
	initial forever #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			$display("BAD %0t watchdog expired", $time);
			n_errors++;
			test_done();
		end
	end
	// ==========================================================
	// Bus and check tasks
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e)
		begin
			$display("BAD %0t got %h want %h", $time, g, e);
			n_errors++;
		end
	endtask
	task automatic rc(input logic [4:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		chk(rv, e);
	endtask
	task automatic wt();
		cl = 0;
		st = 0;
		tot = 0;
		while ((tot < 3 || converting === 1'b1) && tot < 9000)
		begin
			@(posedge ref_clk);
			#1;
			tot++;
			if (sample_switch_closed === 1'b1) cl++;
			if (cl == 1 && st == 0) st = tot;
		end
		if (tot >= 9000)
		begin
			$display("BAD %0t conversion did not end", $time);
			n_errors++;
		end
	endtask
	task automatic run();
		wr(5'h08, 8'h01);
		wt();
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [4:0] ofs [15] = '{2, 3, 4, 5, 6, 8, 9, 10, 11, 16, 17, 18, 19, 20, 21};
		logic [7:0] msk [6] = '{8'h77, 8'hFF, 8'h07, 8'h1F, 8'h1F, 8'h00};
		logic [4:0] chs [6] = '{5'h00, 5'h0B, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
		foreach (ofs[i]) rc(ofs[i], 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			wr(2 + i, 8'hFF);
			rc(2 + i, msk[i]);
		end
		chk({reference_select, sample_cap_select}, 3'h7);
		for (int i = 2; i < 7; i++) wr(i, 8'h00);
		chk({reference_select, sample_cap_select}, 3'h0);
		foreach (chs[i])
		begin
			wr(5'h06, chs[i]);
			rc(5'h06, chs[i]);
			chk(active_channel, chs[i]);
		end
		$display("t_regs done");
	endtask
	task automatic t_div();
		wr(5'h09, 8'h01);
		for (int c = 0; c < 8; c++)
		begin
			wr(5'h02, c);
			run();
			chk(cl, 8 << c);
		end
		wr(5'h02, 8'h00);
		wr(5'h05, 8'h1F);
		run();
		chk(cl, 132);
		wr(5'h05, 8'h00);
		$display("t_div done");
	endtask
	task automatic t_win();
		logic [15:0] lo [2] = '{16'h02AB, 16'h02A9};
		logic [15:0] hi [2] = '{16'h02A9, 16'h02AB};
		logic [4:0] ew [2] = '{5'h16, 5'h08};
		wr(5'h0A, 8'h03);
		for (int s = 0; s < 2; s++)
		begin
			wr(5'h12, lo[s][7:0]);
			wr(5'h13, lo[s][15:8]);
			wr(5'h14, hi[s][7:0]);
			wr(5'h15, hi[s][15:8]);
			for (int m = 0; m < 5; m++)
			begin
				wr(5'h04, m);
				run();
				chk(irq, 1'b1);
				rc(5'h0B, {6'h00, ew[s][m], 1'b1});
				rc(5'h10, 8'hAA);
				rc(5'h0B, 8'h00);
				chk(irq, 1'b0);
			end
		end
		wr(5'h04, 8'h00);
		run();
		wr(5'h0B, 8'h00);
		rc(5'h0B, 8'h01);
		wr(5'h0A, 8'h00);
		chk(irq, 1'b0);
		wr(5'h0A, 8'h01);
		chk(irq, 1'b1);
		wr(5'h0B, 8'h01);
		rc(5'h0B, 8'h00);
		chk(irq, 1'b0);
		$display("t_win done");
	endtask
	task automatic t_delay();
		wr(5'h03, 8'h20);
		wr(5'h09, 8'h00);
		wr(5'h09, 8'h01);
		run();
		chk(st >= 30 && st <= 40, 1'b1);
		run();
		chk(st <= 5, 1'b1);
		wr(5'h09, 8'h03);
		run();
		chk(st >= 30 && st <= 40, 1'b1);
		wr(5'h09, 8'h01);
		wr(5'h03, 8'h00);
		run();
		t0 = tot;
		wr(5'h03, 8'h05);
		run();
		chk(tot - t0 >= 9 && tot - t0 <= 11, 1'b1);
		chk(cl, 8);
		wr(5'h03, 8'h1F);
		run();
		rc(5'h03, 8'h11);
		wr(5'h03, 8'h00);
		$display("t_delay done");
	endtask
	task automatic t_mux_abort();
		wr(5'h06, 8'h03);
		wr(5'h08, 8'h01);
		wr(5'h06, 8'h09);
		chk(active_channel, 5'h03);
		wt();
		repeat (2) @(posedge ref_clk);
		#1 chk(active_channel, 5'h09);
		rc(5'h10, 8'hAA);
		rc(5'h11, 8'h02);
		wr(5'h08, 8'h01);
		rc(5'h08, 8'h01);
		wr(5'h08, 8'h00);
		repeat (2) @(posedge ref_clk);
		#1 chk(converting, 1'b0);
		rc(5'h08, 8'h00);
		rc(5'h0B, 8'h00);
		$display("t_mux_abort done");
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs();
		t_div();
		t_win();
		t_delay();
		t_mux_abort();
		test_done();
	end
endmodule // adc_timing_window_mux_control_tb_top
